// [rtl/fault_conf_regs.vh]
/*
  Register offsets, thresholds and increments of the fault confinement block.
  Assumes inclusion by bare name from rtl/ design files.
*/
`ifndef FAULT_CONF_REGS_VH
`define FAULT_CONF_REGS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define FC_OFS_TALLY      8'h00
`define FC_OFS_STATE      8'h04
`define FC_OFS_CTRL       8'h08
`define FC_OFS_ERRS       8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FC_CTRL_ENABLE    0
`define FC_CTRL_WAKE      1
`define FC_TALLY_OUT_LSB  8

// ----------------------------------------
// Thresholds and increments
// ----------------------------------------
`define FC_IDLE_BITS      4'hB
`define FC_WARN_LIMIT     9'h060
`define FC_PASSIVE_LIMIT  9'h080
`define FC_BUSOFF_LIMIT   9'h100
`define FC_RECOVER_SEQS   8'h80
`define FC_STUFF_RUN      3'h6
`define FC_DOM_ACTIVE     5'h0E
`define FC_DOM_PASSIVE    5'h08
`define FC_DOM_MORE       5'h08
`define FC_INC_BIG        9'h008
`define FC_INC_ONE        9'h001

`endif

// [rtl/can_fault_confinement.v]
/*
  Error detection and fault confinement of a CAN controller: error checks,
  inbound and outbound fault tallies, the confinement state machine and an
  AXI4-Lite register slave.
  Assumes a bit-timing unit supplying a one-cycle bit_tick at each sample point
  and a frame engine supplying field qualifiers, frame events and CRC bits.
*/
`timescale 1ns/1ps
`include "fault_conf_regs.vh"

module can_fault_confinement #(
  parameter RECOVER_SEQS = `FC_RECOVER_SEQS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        bit_tick,
  input  wire        rx_bit,
  input  wire        tx_bit,
  input  wire        transmitting,
  input  wire        in_arbitration,
  input  wire        in_stuffed_field,
  input  wire        stuff_bit_slot,
  input  wire        fixed_bit_slot,
  input  wire        fixed_bit_value,
  input  wire        last_eof_bit,
  input  wire        ack_slot,
  input  wire        crc_bit_valid,
  input  wire        crc_check,
  input  wire        sending_flag,
  input  wire        flag_first_after,
  input  wire        flag_was_overload,
  input  wire        frame_ok,
  output reg         bus_drive_en,
  output reg         error_flag_dominant,
  output reg         error_pulse,
  input  wire [7:0]  s_axil_awaddr,
  input  wire        s_axil_awvalid,
  output wire        s_axil_awready,
  input  wire [31:0] s_axil_wdata,
  input  wire [3:0]  s_axil_wstrb,
  input  wire        s_axil_wvalid,
  output wire        s_axil_wready,
  output reg  [1:0]  s_axil_bresp,
  output reg         s_axil_bvalid,
  input  wire        s_axil_bready,
  input  wire [7:0]  s_axil_araddr,
  input  wire        s_axil_arvalid,
  output wire        s_axil_arready,
  output reg  [31:0] s_axil_rdata,
  output reg  [1:0]  s_axil_rresp,
  output reg         s_axil_rvalid,
  input  wire        s_axil_rready
);

  // ----------------------------------------
  // States, one-hot
  // ----------------------------------------
  localparam [4:0] ST_SYNC    = 5'h01;
  localparam [4:0] ST_ACTIVE  = 5'h02;
  localparam [4:0] ST_WARN    = 5'h04;
  localparam [4:0] ST_PASSIVE = 5'h08;
  localparam [4:0] ST_BUSOFF  = 5'h10;

  reg  [4:0]  state_q;
  reg  [4:0]  state_d;
  reg  [7:0]  inbound_fault_tally_q;
  reg  [7:0]  outbound_fault_tally_q;
  reg  [8:0]  in_next;
  reg  [8:0]  out_next;
  reg  [3:0]  idle_cnt_q;
  reg  [7:0]  seq_cnt_q;
  reg  [2:0]  run_cnt_q;
  reg         last_bit_q;
  reg  [14:0] crc_q;
  reg  [4:0]  dom_cnt_q;
  reg         dom_armed_q;
  reg         dom_passive_q;
  reg         flag_dom_seen_q;
  reg  [1:0]  enable_q;
  reg  [4:0]  err_seen_q;

  wire active_like = state_q[1] | state_q[2];
  wire on_bus      = active_like | state_q[3];

  // ----------------------------------------
  // Error detection
  // ----------------------------------------
  wire dom_for_rec  = ~rx_bit & tx_bit;
  wire bit_exempt   = dom_for_rec & ((sending_flag & state_q[3]) | in_arbitration | ack_slot);
  wire bit_err      = transmitting & (rx_bit != tx_bit) & ~bit_exempt & ~ack_slot;
  wire stuff_err    = in_stuffed_field & (rx_bit == last_bit_q)
                      & (run_cnt_q == (`FC_STUFF_RUN - 3'h1));
  wire form_err     = fixed_bit_slot & (rx_bit != fixed_bit_value)
                      & ~(last_eof_bit & ~transmitting & ~rx_bit);
  wire crc_err      = crc_check & ~transmitting & (crc_q != 15'h0000);
  wire ack_err      = ack_slot & transmitting & rx_bit;
  wire arb_stuff    = stuff_err & in_arbitration & transmitting & stuff_bit_slot & tx_bit & ~rx_bit;
  wire ack_exempt   = ack_err & state_q[3];
  wire other_err    = (stuff_err | form_err | crc_err | ack_err) & ~sending_flag;
  wire flag_bit_err = sending_flag & ~state_q[3] & (rx_bit != tx_bit);
  wire first_dom    = flag_first_after & ~transmitting & ~rx_bit;
  wire dom_hit      = dom_armed_q & ~rx_bit &
                      (dom_cnt_q == (dom_passive_q ? `FC_DOM_PASSIVE : `FC_DOM_ACTIVE) - 5'h01);
  wire any_err      = bit_err | other_err | flag_bit_err;

  wire crc_fb = rx_bit ^ crc_q[14];

  always @(posedge aclk) begin
    if (!aresetn) begin
      run_cnt_q       <= 3'h0;
      last_bit_q      <= 1'b1;
      crc_q           <= 15'h0000;
      dom_cnt_q       <= 5'h00;
      dom_armed_q     <= 1'b0;
      dom_passive_q   <= 1'b0;
      flag_dom_seen_q <= 1'b0;
    end else if (bit_tick) begin
      last_bit_q <= rx_bit;
      if (!in_stuffed_field || rx_bit != last_bit_q)
        run_cnt_q <= 3'h1;
      else if (run_cnt_q != `FC_STUFF_RUN)
        run_cnt_q <= run_cnt_q + 3'h1;
      // Polynomial x15+x14+x10+x8+x7+x4+x3+1
      if (!in_stuffed_field && !crc_bit_valid)
        crc_q <= 15'h0000;
      else if (crc_bit_valid)
        crc_q <= {crc_q[13:0], 1'b0} ^ (crc_fb ? 15'h4599 : 15'h0000);
      if (sending_flag && state_q[3] && !rx_bit)
        flag_dom_seen_q <= 1'b1;
      else if (!sending_flag)
        flag_dom_seen_q <= 1'b0;
      // Dominant run after a flag; counter restarts every eight more
      if (flag_first_after && !rx_bit) begin
        dom_armed_q   <= 1'b1;
        dom_passive_q <= state_q[3] & ~flag_was_overload;
        dom_cnt_q     <= 5'h01;
      end else if (dom_armed_q && !rx_bit) begin
        if (dom_hit) begin
          dom_passive_q <= 1'b1;
          dom_cnt_q     <= 5'h00;
        end else
          dom_cnt_q <= dom_cnt_q + 5'h01;
      end else begin
        dom_armed_q <= 1'b0;
        dom_cnt_q   <= 5'h00;
      end
    end
  end

  // ----------------------------------------
  // Fault tallies
  // ----------------------------------------
  always @* begin
    in_next  = {1'b0, inbound_fault_tally_q};
    out_next = {1'b0, outbound_fault_tally_q};
    if (bit_tick && on_bus) begin
      if (transmitting) begin
        if (flag_bit_err | dom_hit | bit_err)
          out_next = out_next + `FC_INC_BIG;
        else if (other_err && !arb_stuff && !(ack_exempt && !flag_dom_seen_q))
          out_next = out_next + `FC_INC_BIG;
        else if (frame_ok && out_next != 9'h000)
          out_next = out_next - `FC_INC_ONE;
      end else if (!inbound_fault_tally_q[7]) begin
        if (flag_bit_err | first_dom | dom_hit)
          in_next = in_next + `FC_INC_BIG;
        else if (other_err | bit_err)
          in_next = in_next + `FC_INC_ONE;
        else if (frame_ok && in_next != 9'h000)
          in_next = in_next - `FC_INC_ONE;
      end else if (frame_ok)
        in_next = in_next - `FC_INC_ONE;
    end
    if (in_next > 9'h0FF)
      in_next = 9'h0FF;
  end

  // ----------------------------------------
  // Confinement state machine
  // ----------------------------------------
  wire idle_done = bit_tick & rx_bit & (idle_cnt_q == `FC_IDLE_BITS - 4'h1);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SYNC:
        if (idle_done) state_d = ST_ACTIVE;
      ST_ACTIVE, ST_WARN, ST_PASSIVE: begin
        if (out_next >= `FC_BUSOFF_LIMIT)
          state_d = ST_BUSOFF;
        else if (out_next >= `FC_PASSIVE_LIMIT || in_next >= `FC_PASSIVE_LIMIT)
          state_d = ST_PASSIVE;
        else if (out_next >= `FC_WARN_LIMIT || in_next >= `FC_WARN_LIMIT)
          state_d = ST_WARN;
        else
          state_d = ST_ACTIVE;
      end
      ST_BUSOFF:
        if (idle_done && seq_cnt_q == RECOVER_SEQS[7:0] - 8'h01)
          state_d = ST_ACTIVE;
      default: state_d = ST_SYNC;
    endcase
    if (!enable_q[0])
      state_d = ST_SYNC;
    else if (enable_q[1])
      state_d = ST_SYNC;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q                <= ST_SYNC;
      inbound_fault_tally_q  <= 8'h00;
      outbound_fault_tally_q <= 8'h00;
      idle_cnt_q             <= 4'h0;
      seq_cnt_q              <= 8'h00;
      bus_drive_en           <= 1'b0;
      error_flag_dominant    <= 1'b0;
      error_pulse            <= 1'b0;
      err_seen_q             <= 5'h00;
    end else begin
      state_q     <= state_d;
      error_pulse <= bit_tick & any_err;
      if (bit_tick)
        err_seen_q <= err_seen_q | {ack_err, crc_err, form_err, stuff_err, bit_err};
      if (state_d == ST_BUSOFF && state_q != ST_BUSOFF) begin
        inbound_fault_tally_q  <= in_next[7:0];
        outbound_fault_tally_q <= 8'hFF;
      end else if (state_q[4] && state_d[1]) begin
        inbound_fault_tally_q  <= 8'h00;
        outbound_fault_tally_q <= 8'h00;
      end else if (!state_q[0] && !state_q[4]) begin
        inbound_fault_tally_q  <= in_next[7:0];
        outbound_fault_tally_q <= out_next[7:0];
      end
      // Stale recessive count must not shorten a fresh wait
      if (!enable_q[0] || enable_q[1] || (state_d[4] && !state_q[4]))
        idle_cnt_q <= 4'h0;
      else if (bit_tick && (!rx_bit || idle_done))
        idle_cnt_q <= 4'h0;
      else if (bit_tick)
        idle_cnt_q <= idle_cnt_q + 4'h1;
      if (bit_tick) begin
        if (!state_q[4])
          seq_cnt_q <= 8'h00;
        else if (idle_done)
          seq_cnt_q <= seq_cnt_q + 8'h01;
      end
      bus_drive_en <= state_d[1] | state_d[2] | state_d[3];
      // Flag style chosen from the state before the error's own update
      if (bit_tick && any_err)
        error_flag_dominant <= active_like;
    end
  end

  // ----------------------------------------
  // Control
  // ----------------------------------------
  wire wr_fire;
  wire [31:0] wr_data;
  reg  [7:0]  aw_q;
  reg  [31:0] w_q;
  reg         aw_have_q;
  reg         w_have_q;

  always @(posedge aclk) begin
    if (!aresetn)
      enable_q <= 2'b00;
    else begin
      enable_q[1] <= 1'b0;
      // Strobe already applied when the data word was latched
      if (wr_fire && aw_q == `FC_OFS_CTRL) begin
        enable_q[0] <= wr_data[`FC_CTRL_ENABLE];
        enable_q[1] <= wr_data[`FC_CTRL_WAKE];
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data latched independently, response after both
  assign s_axil_awready = ~aw_have_q & ~s_axil_bvalid;
  assign s_axil_wready  = ~w_have_q & ~s_axil_bvalid;
  assign s_axil_arready = ~s_axil_rvalid;
  assign wr_fire        = aw_have_q & w_have_q & ~s_axil_bvalid;
  assign wr_data        = w_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 8'h00;
      w_q           <= 32'h0000_0000;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= 2'b00;
      s_axil_rvalid <= 1'b0;
      s_axil_rresp  <= 2'b00;
      s_axil_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_q      <= s_axil_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_q      <= s_axil_wstrb[0] ? s_axil_wdata : 32'h0000_0000;
        w_have_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= (aw_q == `FC_OFS_CTRL) ? 2'b00 : 2'b10;
      end else if (s_axil_bvalid && s_axil_bready)
        s_axil_bvalid <= 1'b0;
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rresp  <= 2'b00;
        case (s_axil_araddr)
          `FC_OFS_TALLY: s_axil_rdata <= {16'h0000, outbound_fault_tally_q, inbound_fault_tally_q};
          `FC_OFS_STATE: s_axil_rdata <= {27'h0, state_q};
          `FC_OFS_CTRL:  s_axil_rdata <= {31'h0, enable_q[0]};
          `FC_OFS_ERRS:  s_axil_rdata <= {27'h0, err_seen_q};
          default: begin
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= 2'b10;
          end
        endcase
      end else if (s_axil_rvalid && s_axil_rready)
        s_axil_rvalid <= 1'b0;
    end
  end

endmodule // can_fault_confinement

// [tb/can_fault_confinement_sva.sv]
/*
  Checker for the fault confinement block: error pulse timing, resync wait
  and register bus handshakes.
  Assumes binding to can_fault_confinement with matching port names.
*/
`timescale 1ns/1ps
module can_fault_confinement_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bit_tick,
  input wire logic rx_bit,
  input wire logic tx_bit,
  input wire logic transmitting,
  input wire logic in_arbitration,
  input wire logic ack_slot,
  input wire logic sending_flag,
  input wire logic bus_drive_en,
  input wire logic error_pulse,
  input wire logic s_axil_awready,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----
  // Recessive run, saturating at eleven
  // ----
  logic [3:0] rec_run_q;
  always @(posedge aclk) begin
    if (!aresetn) rec_run_q <= 4'h0;
    else if (bit_tick && !rx_bit) rec_run_q <= 4'h0;
    else if (bit_tick && rec_run_q != 4'hB) rec_run_q <= rec_run_q + 4'h1;
  end

  sequence bit_mismatch;
    bit_tick && transmitting && bus_drive_en && tx_bit && !rx_bit && !in_arbitration && !ack_slot && !sending_flag;
  endsequence
  sequence ar_taken;
    s_axil_arvalid && s_axil_arready;
  endsequence

  a_bit_error: assert property (bit_mismatch |=> error_pulse)
    else $error("bit mismatch not flagged");
  a_pulse_cause: assert property (error_pulse |-> $past(bit_tick))
    else $error("error pulse without bit tick");
  a_sync_wait: assert property ($rose(bus_drive_en) |-> rec_run_q == 4'hB)
    else $error("joined bus before eleven recessive bits");
  a_w_refused: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write accepted during response");
  a_ar_refused: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read accepted during response");
  a_r_latency: assert property (ar_taken |=> s_axil_rvalid)
    else $error("read data late");
  a_r_once: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
    else $error("read response repeated");
  a_b_once: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
    else $error("write response repeated");
endmodule // can_fault_confinement_sva

bind can_fault_confinement can_fault_confinement_sva can_fault_confinement_sva_inst (.*);

// [tb/can_bus_node.sv]
/*
  Other nodes on the shared bus: wired-AND of this node and a jamming node.
  Assumes the bench steers the jam level between bit ticks.
*/
`timescale 1ns/1ps
module can_bus_node (
  input  wire logic tx_bit,
  input  wire logic drive_en,
  input  wire logic jam,
  output wire logic rx_bit
);
  // Released driver reads as the recessive pull level
  assign rx_bit = (tx_bit | ~drive_en) & ~jam;
endmodule // can_bus_node

// [tb/can_fault_confinement_bench.sv]
/*
  Self-checking bench: registers, resync, receive and transmit tallies,
  bus off and recovery.
  Assumes rtl/ on the include path and RECOVER_SEQS shortened to 8.
*/
`timescale 1ns/1ps
module can_fault_confinement_bench;
  logic aclk = 1'b0, aresetn = 1'b0, bit_tick = 1'b0, tx_bit = 1'b1, jam = 1'b0;
  logic transmitting = 1'b0, in_stuffed_field = 1'b0, fixed_bit_slot = 1'b0, ack_slot = 1'b0, frame_ok = 1'b0;
  logic in_arbitration = 1'b0, stuff_bit_slot = 1'b0, fixed_bit_value = 1'b1, last_eof_bit = 1'b0;
  logic crc_bit_valid = 1'b0, crc_check = 1'b0, sending_flag = 1'b0, flag_first_after = 1'b0;
  logic flag_was_overload = 1'b0, rx_bit, bus_drive_en, error_flag_dominant, error_pulse;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0, s_axil_arvalid = 1'b0;
  logic s_axil_rready = 1'b0, s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  int fail_count = 0, n_checks = 0;

  always #25 aclk = ~aclk;
  can_fault_confinement #(.RECOVER_SEQS(8)) can_fault_confinement_inst (.*);
  can_bus_node can_bus_node_inst (.tx_bit(tx_bit), .drive_en(bus_drive_en), .jam(jam), .rx_bit(rx_bit));

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bits(input int n, input logic ok = 1'b0);
    repeat (n) begin
      bit_tick <= 1'b1;
      frame_ok <= ok;
      @(posedge aclk);
      bit_tick <= 1'b0;
      frame_ok <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    chk({s_axil_rresp, s_axil_rdata}, {r, e});
    // Next call must not re-drive ready in this step
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axil_awready === 1'b1) begin
        aw = 1'b1;
        s_axil_awvalid <= 1'b0;
      end
      if (s_axil_wready === 1'b1) begin
        w = 1'b1;
        s_axil_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    chk({32'h0, s_axil_bresp}, {32'h0, r});
    @(posedge aclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h00, 32'hFFFF, 2'h2);
    rd(8'h00, 32'h0);
    wr(8'h08, 32'h1, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_sync;
    bits(10);
    rd(8'h04, 32'h1);
    bits(1);
    rd(8'h04, 32'h2);
    chk(bus_drive_en, 1'b1);
    $display("test sync done");
  endtask
  task automatic t_rx;
    in_stuffed_field <= 1'b1;
    jam <= 1'b1;
    bits(5);
    rd(8'h00, 32'h0);
    bits(1);
    rd(8'h00, 32'h1);
    in_stuffed_field <= 1'b0;
    fixed_bit_slot <= 1'b1;
    bits(1);
    rd(8'h00, 32'h2);
    fixed_bit_slot <= 1'b0;
    jam <= 1'b0;
    bits(3, 1'b1);
    rd(8'h00, 32'h0);
    $display("test receive done");
  endtask
  task automatic t_tx;
    transmitting <= 1'b1;
    ack_slot <= 1'b1;
    bits(12);
    rd(8'h00, 32'h6000);
    rd(8'h04, 32'h4);
    ack_slot <= 1'b0;
    bits(1, 1'b1);
    rd(8'h00, 32'h5F00);
    rd(8'h04, 32'h2);
    jam <= 1'b1;
    bits(4);
    rd(8'h04, 32'h4);
    bits(1);
    rd(8'h04, 32'h8);
    chk(error_flag_dominant, 1'b1);
    bits(1);
    chk(error_flag_dominant, 1'b0);
    bits(14);
    rd(8'h00, 32'hFF00);
    rd(8'h04, 32'h8);
    bits(1);
    rd(8'h04, 32'h10);
    chk(bus_drive_en, 1'b0);
    $display("test transmit done");
  endtask
  task automatic t_recover;
    jam <= 1'b0;
    transmitting <= 1'b0;
    bits(87);
    rd(8'h04, 32'h10);
    bits(1);
    rd(8'h04, 32'h2);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h17);
    wr(8'h08, 32'h3, 2'h0);
    rd(8'h04, 32'h1);
    bits(10);
    rd(8'h04, 32'h1);
    bits(1);
    rd(8'h04, 32'h2);
    $display("test recover done");
  endtask
  task automatic t_more;
    transmitting <= 1'b1;
    in_arbitration <= 1'b1;
    in_stuffed_field <= 1'b1;
    stuff_bit_slot <= 1'b1;
    jam <= 1'b1;
    bits(6);
    rd(8'h00, 32'h0);
    transmitting <= 1'b0;
    in_arbitration <= 1'b0;
    in_stuffed_field <= 1'b0;
    stuff_bit_slot <= 1'b0;
    sending_flag <= 1'b1;
    bits(1);
    rd(8'h00, 32'h8);
    sending_flag <= 1'b0;
    flag_first_after <= 1'b1;
    bits(1);
    rd(8'h00, 32'h10);
    flag_first_after <= 1'b0;
    bits(12);
    rd(8'h00, 32'h10);
    bits(1);
    rd(8'h00, 32'h18);
    bits(8);
    rd(8'h00, 32'h20);
    crc_bit_valid <= 1'b1;
    bits(1);
    crc_bit_valid <= 1'b0;
    crc_check <= 1'b1;
    bits(1);
    rd(8'h00, 32'h20);
    jam <= 1'b0;
    crc_bit_valid <= 1'b1;
    crc_check <= 1'b0;
    bits(1);
    crc_bit_valid <= 1'b0;
    crc_check <= 1'b1;
    bits(1);
    crc_check <= 1'b0;
    rd(8'h00, 32'h21);
    flag_first_after <= 1'b1;
    jam <= 1'b1;
    bits(12);
    rd(8'h00, 32'h81);
    rd(8'h04, 32'h8);
    bits(2);
    rd(8'h00, 32'h81);
    flag_first_after <= 1'b0;
    jam <= 1'b0;
    bits(2, 1'b1);
    rd(8'h00, 32'h7F);
    rd(8'h04, 32'h4);
    flag_first_after <= 1'b1;
    jam <= 1'b1;
    bits(1);
    flag_first_after <= 1'b0;
    jam <= 1'b0;
    transmitting <= 1'b1;
    ack_slot <= 1'b1;
    bits(3);
    rd(8'h00, 32'h87);
    rd(8'h04, 32'h8);
    transmitting <= 1'b0;
    ack_slot <= 1'b0;
    $display("test flags done");
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_sync();
    t_rx();
    t_tx();
    t_recover();
    t_more();
    stop_test();
  end
  // Generous: the run needs well under a tenth of this
  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end
endmodule // can_fault_confinement_bench
